// File: src/led_ctl_consts.svh
// register map, field positions, reset values and timing counts of the led matrix link
`ifndef LED_CTL_CONSTS_SVH
`define LED_CTL_CONSTS_SVH

// matrix geometry
`define N_SRC_DEF 11
`define N_SINK_DEF 18
`define SINK_GRP 6
`define PWM_STEPS 256

// device pages
`define PAGE_DIM 2'd0
`define PAGE_EN 2'd1
`define PAGE_FUNC 2'd2

// function page offsets
`define REG_CFG 8'h00
`define REG_GCC 8'h01
`define REG_PULL 8'h02
`define REG_RES_FIRST 8'h03
`define REG_RES_LAST 8'h23
`define REG_RESET 8'h2f
`define REG_IST 8'h30
`define REG_IMASK 8'h31

// configuration fields
`define CFG_SSD_BIT 0
`define CFG_SEL_LSB 1
`define CFG_SEL_MASK 8'h06
`define SEL_OFF 2'b00
`define SEL_OPEN 2'b01
`define SEL_SHORT 2'b10
`define PULL_SRC_LSB 4
`define PULL_SINK_LSB 0
`define RESET_KEY 8'hae
`define FUNC_RST 8'h00

// device status bits
`define IST_DONE 0
`define IST_FAULT 1

// detection preconditions
`define GCC_MIN_A 8'h0f
`define GCC_MIN_B 8'h01
`define GCC_MAX 8'h40
`define PULL_A 8'h00
`define PULL_B 8'h30

// timing
`define CLK_NS 5
`define SCAN_SLOT_NS 33000
`define TICK_DIV_DEF (`SCAN_SLOT_NS / (`CLK_NS * `PWM_STEPS))
`define DETECT_WAIT_NS (2 * `N_SRC_DEF * `SCAN_SLOT_NS)
`define DETECT_WAIT_DEF ((`DETECT_WAIT_NS + `CLK_NS - 1) / `CLK_NS)

// host axi4-lite offsets and fields
`define HREG_CTRL 8'h00
`define HREG_ADDR 8'h04
`define HREG_WDATA 8'h08
`define HREG_RDATA 8'h0c
`define HREG_STAT 8'h10
`define HREG_IST 8'h14
`define HREG_IMASK 8'h18
`define CTRL_GO 0
`define CTRL_WRITE 1
`define CTRL_PIN 2
`define HIST_DONE 0
`define HIST_REFUSED 1
`define HIST_DEV 2
`define HOST_PIN_RST 1'b1
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10

`endif

// File: src/led_ctl_pkg.sv
// state types shared by both ends of the led matrix link
package led_ctl_pkg;
	typedef enum logic {
		DET_IDLE,
		DET_RUN
	} det_state_t;

	typedef enum logic [1:0] {
		H_IDLE,
		H_START,
		H_CLEAR,
		H_XFER
	} host_state_t;
endpackage

// File: src/led_link_if.sv
// register link between host controller and led matrix device
`timescale 1ns/1ps
interface led_link_if;
	logic req;
	logic we;
	logic [1:0] page;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic ack;
	logic shutdown_pin_n;
	logic dev_irq;

	modport dev (
		input req, we, page, addr, wdata, shutdown_pin_n,
		output rdata, ack, dev_irq
	);
	modport host (
		output req, we, page, addr, wdata, shutdown_pin_n,
		input rdata, ack, dev_irq
	);
endinterface

// File: src/led_matrix_device.sv
// led matrix device: pwm scan, fault detection, anti-ghost pulls, shutdown
//
// Design decision made here: the req/ack register link to the registers; the AXI4-Lite interface sits in the host.
`timescale 1ns/1ps
`include "led_ctl_consts.svh"

// Operation
// - pwm dimming only, 256 steps per led
// - dimming value is plain step count
// - select 00 to 01/10 starts detection
// - host waits two scans before reading results
// - disabled leds keep their result bits
// - host sets current and pulls before trigger
// - one-shot detect; clear then set again
// - selectable source pull-down, sink pull-up
// - pulls only while output is off
// - registers kept through both shutdowns
// - soft shutdown bit zero blanks sinks
// - pin low disables analog, high releases
// - registers accessible during hardware shutdown
// - result regs: six low bits, top zero
// - reset key 0xae restores all defaults
module led_matrix_device import led_ctl_pkg::*; #(
	parameter int N_SRC = `N_SRC_DEF,
	parameter int N_SINK = `N_SINK_DEF,
	parameter int TICK_DIV = `TICK_DIV_DEF
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register link
	led_link_if.dev link,
	// fault sense from the sink stages
	input wire logic [N_SINK-1:0] open_sense,
	input wire logic [N_SINK-1:0] short_sense,
	// matrix drive
	output logic [N_SRC-1:0] source_on,
	output logic [N_SINK-1:0] sink_on,
	output logic [N_SRC-1:0] source_pull_en,
	output logic [N_SINK-1:0] sink_pull_en,
	output logic [2:0] source_pull_code,
	output logic [2:0] sink_pull_code,
	output logic analog_enable,
	output logic irq
);
	localparam int NLED = N_SRC * N_SINK;
	localparam int NGRP = N_SINK / `SINK_GRP;
	localparam int SRC_W = $clog2(N_SRC);

	typedef struct packed {
		logic [NLED-1:0][7:0] pwm;
		logic [NLED-1:0] en;
		logic [NLED-1:0] res;
		logic [7:0] cfg;
		logic [7:0] global_current_control;
		logic [7:0] pull;
		logic [1:0] ist;
		logic [1:0] imask;
		logic ack;
		logic [7:0] rdata;
		logic [7:0] div;
		logic [7:0] pcnt;
		logic [SRC_W-1:0] src;
		det_state_t det;
		logic [1:0] mode;
		logic scans;
		logic found;
	} dev_state_t;

	dev_state_t s_q;
	dev_state_t s_d;
	logic running;
	logic tick;
	logic slot_end;
	logic scan_end;
	logic [N_SINK-1:0] sense;

	// scan timing derived from the clock divider
	assign tick = s_q.div == 8'(TICK_DIV - 1);
	assign slot_end = tick && s_q.pcnt == 8'hff;
	assign scan_end = slot_end && s_q.src == SRC_W'(N_SRC - 1);
	assign sense = (s_q.mode == `SEL_SHORT) ? short_sense : open_sense;
	assign running = s_q.cfg[`CFG_SSD_BIT] && link.shutdown_pin_n;

	// next-state logic: scan, register access, detection, reset key
	always_comb begin
		int idx;
		int k;
		logic [1:0] nsel;
		s_d = s_q;
		idx = 0;
		k = 0;
		nsel = `SEL_OFF;
		s_d.ack = 1'b0;
		// scan keeps running through shutdown so resume is seamless
		s_d.div = tick ? 8'h00 : s_q.div + 8'h01;
		if (tick) begin
			s_d.pcnt = s_q.pcnt + 8'h01;
		end
		if (slot_end) begin
			s_d.src = scan_end ? '0 : s_q.src + SRC_W'(1);
		end
		if (link.req && !s_q.ack) begin
			s_d.ack = 1'b1;
			s_d.rdata = 8'h00;
			unique case (link.page)
				`PAGE_DIM: begin
					if (int'(link.addr) < NLED) begin
						if (link.we) begin
							s_d.pwm[link.addr] = link.wdata;
						end
						s_d.rdata = s_q.pwm[link.addr];
					end
				end
				`PAGE_EN: begin
					for (int b = 0; b < 8; b++) begin
						idx = int'(link.addr) * 8 + b;
						if (idx < NLED) begin
							if (link.we) begin
								s_d.en[idx] = link.wdata[b];
							end
							s_d.rdata[b] = s_q.en[idx];
						end
					end
				end
				`PAGE_FUNC: begin
					if (link.addr == `REG_CFG) begin
						s_d.rdata = s_q.cfg;
						if (link.we) begin
							s_d.cfg = link.wdata;
							nsel = link.wdata[`CFG_SEL_LSB +: 2];
							if (s_q.cfg[`CFG_SEL_LSB +: 2] == `SEL_OFF &&
									(nsel == `SEL_OPEN || nsel == `SEL_SHORT)) begin
								s_d.det = DET_RUN;
								s_d.mode = nsel;
								s_d.scans = 1'b0;
								s_d.found = 1'b0;
							end
						end
					end else if (link.addr == `REG_GCC) begin
						s_d.rdata = s_q.global_current_control;
						if (link.we) begin
							s_d.global_current_control = link.wdata;
						end
					end else if (link.addr == `REG_PULL) begin
						s_d.rdata = s_q.pull;
						if (link.we) begin
							s_d.pull = link.wdata;
						end
					end else if (link.addr >= `REG_RES_FIRST &&
							int'(link.addr - `REG_RES_FIRST) < N_SRC * NGRP) begin
						k = int'(link.addr - `REG_RES_FIRST);
						s_d.rdata = {2'b00, s_q.res[(k / NGRP) * N_SINK +
							(k % NGRP) * `SINK_GRP +: `SINK_GRP]};
					end else if (link.addr == `REG_IST) begin
						s_d.rdata = {6'h00, s_q.ist};
						if (link.we) begin
							s_d.ist = s_q.ist & ~link.wdata[1:0];
						end
					end else if (link.addr == `REG_IMASK) begin
						s_d.rdata = {6'h00, s_q.imask};
						if (link.we) begin
							s_d.imask = link.wdata[1:0];
						end
					end
				end
				default: begin
					s_d.rdata = 8'h00;
				end
			endcase
		end
		// sample each slot at its last step; set after clear so events win
		if (s_q.det == DET_RUN && slot_end) begin
			for (int cs = 0; cs < N_SINK; cs++) begin
				idx = int'(s_q.src) * N_SINK + cs;
				if (s_q.en[idx]) begin
					s_d.res[idx] = sense[cs];
					if (sense[cs]) begin
						s_d.found = 1'b1;
					end
				end
			end
			if (scan_end) begin
				s_d.scans = 1'b1;
				if (s_q.scans) begin
					s_d.det = DET_IDLE;
					s_d.ist[`IST_DONE] = 1'b1;
					// only enabled leds may raise the fault flag
					s_d.ist[`IST_FAULT] = s_d.ist[`IST_FAULT] | s_d.found;
				end
			end
		end
		if (link.req && !s_q.ack && link.we && link.page == `PAGE_FUNC &&
				link.addr == `REG_RESET && link.wdata == `RESET_KEY) begin
			s_d = '0;
			s_d.ack = 1'b1;
		end
	end

	// state register; only reset and the key clear it
	// contents kept in shutdown
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// per-sink and per-source drive and anti-ghost pulls
	generate
		for (genvar cs = 0; cs < N_SINK; cs++) begin : g_sink
			assign sink_on[cs] = running && s_q.en[int'(s_q.src) * N_SINK + cs] &&
				s_q.pcnt < s_q.pwm[int'(s_q.src) * N_SINK + cs];
			assign sink_pull_en[cs] = !sink_on[cs] && sink_pull_code != 3'b000;
		end
		for (genvar x = 0; x < N_SRC; x++) begin : g_src
			assign source_on[x] = running && s_q.src == SRC_W'(x);
			assign source_pull_en[x] = !source_on[x] && source_pull_code != 3'b000;
		end
	endgenerate

	assign source_pull_code = s_q.pull[`PULL_SRC_LSB +: 3];
	assign sink_pull_code = s_q.pull[`PULL_SINK_LSB +: 3];
	assign analog_enable = link.shutdown_pin_n;
	// link answer and interrupt
	assign link.ack = s_q.ack;
	assign link.rdata = s_q.rdata;
	assign irq = |(s_q.ist & s_q.imask);
	assign link.dev_irq = irq;
endmodule

// File: src/led_matrix_host.sv
// host controller: axi4-lite register file driving the led matrix link
`timescale 1ns/1ps
`include "led_ctl_consts.svh"

module led_matrix_host import led_ctl_pkg::*; #(
	parameter int DETECT_WAIT = `DETECT_WAIT_DEF
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// interrupt
	output logic irq,
	// device link
	led_link_if.host link
);
	localparam int WAIT_W = $clog2(DETECT_WAIT + 1);

	typedef struct packed {
		host_state_t st;
		logic we;
		logic [1:0] page;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic pin;
		logic [2:0] ist;
		logic [2:0] imask;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rbus;
		logic [7:0] global_current_control;
		logic [7:0] pull;
		logic [1:0] sel;
		logic [WAIT_W-1:0] wait_cnt;
	} host_state_reg_t;

	host_state_reg_t s_q;
	host_state_reg_t s_d;
	logic aw_take;
	logic ar_take;
	logic is_cfg;
	logic is_res;
	logic [1:0] nsel;
	logic cond_ok;

	// write address and data are taken together, one write in flight
	assign aw_take = s_axi_awvalid && s_axi_wvalid && !s_q.bvalid;
	assign ar_take = s_axi_arvalid && !s_q.rvalid;
	assign is_cfg = s_q.page == `PAGE_FUNC && s_q.addr == `REG_CFG;
	assign is_res = s_q.page == `PAGE_FUNC && s_q.addr >= `REG_RES_FIRST &&
		s_q.addr <= `REG_RES_LAST;
	assign nsel = s_q.wdata[`CFG_SEL_LSB +: 2];
	assign cond_ok = (s_q.global_current_control >= `GCC_MIN_A && s_q.global_current_control <= `GCC_MAX &&
		s_q.pull == `PULL_A) || (s_q.global_current_control >= `GCC_MIN_B &&
		s_q.global_current_control <= `GCC_MAX && s_q.pull == `PULL_B);

	// next-state logic: bus slave, link sequencer, shadows and events
	always_comb begin
		s_d = s_q;
		if (s_q.wait_cnt != '0) begin
			s_d.wait_cnt = s_q.wait_cnt - WAIT_W'(1);
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		// bus writes; byte strobes are ignored, each register is one word
		if (aw_take) begin
			s_d.bvalid = 1'b1;
			s_d.bresp = `AXI_OKAY;
			unique case (s_axi_awaddr)
				`HREG_CTRL: begin
					s_d.pin = s_axi_wdata[`CTRL_PIN];
					if (s_axi_wdata[`CTRL_GO] && s_q.st == H_IDLE) begin
						s_d.we = s_axi_wdata[`CTRL_WRITE];
						s_d.st = H_START;
					end
				end
				`HREG_ADDR: begin
					s_d.page = s_axi_wdata[9:8];
					s_d.addr = s_axi_wdata[7:0];
				end
				`HREG_WDATA: s_d.wdata = s_axi_wdata[7:0];
				`HREG_IST: s_d.ist = s_q.ist & ~s_axi_wdata[2:0];
				`HREG_IMASK: s_d.imask = s_axi_wdata[2:0];
				default: s_d.bresp = `AXI_SLVERR;
			endcase
		end
		// bus reads
		if (ar_take) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = `AXI_OKAY;
			unique case (s_axi_araddr)
				`HREG_CTRL: s_d.rbus = {29'h0, s_q.pin, s_q.we, 1'b0};
				`HREG_ADDR: s_d.rbus = {22'h0, s_q.page, s_q.addr};
				`HREG_WDATA: s_d.rbus = {24'h0, s_q.wdata};
				`HREG_RDATA: s_d.rbus = {24'h0, s_q.rdata};
				`HREG_STAT: s_d.rbus = {30'h0, s_q.wait_cnt != '0, s_q.st != H_IDLE};
				`HREG_IST: s_d.rbus = {29'h0, s_q.ist};
				`HREG_IMASK: s_d.rbus = {29'h0, s_q.imask};
				default: begin
					s_d.rbus = 32'h0;
					s_d.rresp = `AXI_SLVERR;
				end
			endcase
		end
		// link sequencer
		unique case (s_q.st)
			H_IDLE: begin
			end
			H_START: begin
				if (!s_q.we && is_res && s_q.wait_cnt != '0) begin
					s_d.st = H_START;
				end else if (s_q.we && is_cfg && nsel != `SEL_OFF && !cond_ok) begin
					s_d.ist[`HIST_REFUSED] = 1'b1;
					s_d.st = H_IDLE;
				end else if (s_q.we && is_cfg && nsel != `SEL_OFF &&
						s_q.sel != `SEL_OFF) begin
					s_d.st = H_CLEAR;
				end else begin
					s_d.st = H_XFER;
				end
			end
			H_CLEAR: begin
				// back through start so req drops for a cycle between accesses
				if (link.ack) begin
					s_d.sel = `SEL_OFF;
					s_d.st = H_START;
				end
			end
			H_XFER: begin
				if (link.ack) begin
					s_d.rdata = link.rdata;
					s_d.st = H_IDLE;
					s_d.ist[`HIST_DONE] = 1'b1;
					if (s_q.we && s_q.page == `PAGE_FUNC) begin
						if (is_cfg) begin
							s_d.sel = nsel;
							if (s_q.sel == `SEL_OFF && nsel != `SEL_OFF) begin
								s_d.wait_cnt = WAIT_W'(DETECT_WAIT);
							end
						end else if (s_q.addr == `REG_GCC) begin
							s_d.global_current_control = s_q.wdata;
						end else if (s_q.addr == `REG_PULL) begin
							s_d.pull = s_q.wdata;
						end else if (s_q.addr == `REG_RESET && s_q.wdata == `RESET_KEY) begin
							s_d.global_current_control = `FUNC_RST;
							s_d.pull = `FUNC_RST;
							s_d.sel = `SEL_OFF;
						end
					end
				end
			end
		endcase
		// device interrupt level, set wins over a clear
		if (link.dev_irq) begin
			s_d.ist[`HIST_DEV] = 1'b1;
		end
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.pin <= `HOST_PIN_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// bus handshakes and data
	assign s_axi_awready = aw_take;
	assign s_axi_wready = aw_take;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rbus;
	assign s_axi_rresp = s_q.rresp;
	assign irq = |(s_q.ist & s_q.imask);
	// link drive; the clear step forces a select-off write to the config reg
	assign link.req = s_q.st == H_CLEAR || s_q.st == H_XFER;
	assign link.we = s_q.st == H_CLEAR || s_q.we;
	assign link.page = (s_q.st == H_CLEAR) ? `PAGE_FUNC : s_q.page;
	assign link.addr = (s_q.st == H_CLEAR) ? `REG_CFG : s_q.addr;
	assign link.wdata = (s_q.st == H_CLEAR) ? (s_q.wdata & ~`CFG_SEL_MASK) : s_q.wdata;
	assign link.shutdown_pin_n = s_q.pin;
endmodule

// File: sim/led_link_assertions.sv
// protocol checker for the led matrix register link
`timescale 1ns/1ps
`include "led_ctl_consts.svh"
module led_link_assertions (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// link signals
	input wire logic req,
	input wire logic we,
	input wire logic [1:0] page,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic ack,
	input wire logic shutdown_pin_n,
	input wire logic dev_irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// one access: taken, answered by a single pulse, then released
	sequence take_s;
		req && !ack;
	endsequence
	sequence answer_s;
		ack ##1 (!ack && !req);
	endsequence
	access_answer_a: assert property (take_s |=> answer_s)
		else $error("link access not answered in one cycle");
	off_access_a: assert property (req && !ack && !shutdown_pin_n |=> ack)
		else $error("access refused during pin shutdown");
	ack_cause_a: assert property (ack |-> req && $past(req) && !$past(ack))
		else $error("answer without a pending access");
	req_hold_a: assert property (take_s |=> $stable({we, page, addr, wdata}))
		else $error("request changed before answer");
	rdata_hold_a: assert property ($changed(rdata) |-> ack)
		else $error("read data changed outside an answer");
	result_top_a: assert property (ack && !we && page == `PAGE_FUNC
		&& addr >= `REG_RES_FIRST && addr <= `REG_RES_LAST |-> rdata[7:6] == 2'b00)
		else $error("result top bits not zero");
	key_reset_a: assert property (ack && we && page == `PAGE_FUNC && addr == `REG_RESET
		&& wdata == `RESET_KEY |=> !dev_irq)
		else $error("reset key left interrupt set");
	status_clear_a: assert property (ack && we && page == `PAGE_FUNC && addr == `REG_IST
		&& wdata == 8'hff |=> !dev_irq)
		else $error("status clear left interrupt set");
endmodule

// File: sim/led_matrix_dimming_detect_shutdown_tb.sv
// self-checking bench: axi host controller driving the led matrix device
`timescale 1ns/1ps
`include "led_ctl_consts.svh"
module led_matrix_dimming_detect_shutdown_tb import led_ctl_pkg::*;;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic pin = 1'b1;
	logic awready, wready, bvalid, arready, rvalid, irq, dirq, aen;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [17:0] osense = 18'h0;
	logic [17:0] ssense = 18'h0;
	logic [17:0] sink_on, sink_pe;
	logic [10:0] src_on, src_pe;
	logic [2:0] spc, kpc;
	wire logic [3:0] hsv;
	logic [31:0] rexp[$], rmask[$];
	logic [1:0] rrexp[$], bexp[$];
	logic [7:0] dv[4] = '{8'h00, 8'h04, 8'h00, 8'hff};
	logic [7:0] fa[5] = '{`REG_CFG, `REG_GCC, `REG_PULL, `REG_RES_FIRST, `REG_RES_LAST};
	logic [7:0] g, keep;
	logic [31:0] cnt;
	int mismatches = 0;
	int comparisons = 0;
	led_link_if link();
	assign hsv = {rvalid, arready, bvalid, awready};
	always #2.5 aclk = ~aclk;

	// both ends joined by the link, one scan step per clock
	led_matrix_device #(.TICK_DIV(1)) i_led_matrix_device (.aclk(aclk), .aresetn(aresetn),
		.link(link.dev), .open_sense(osense), .short_sense(ssense), .source_on(src_on),
		.sink_on(sink_on), .source_pull_en(src_pe), .sink_pull_en(sink_pe),
		.source_pull_code(spc), .sink_pull_code(kpc), .analog_enable(aen), .irq(dirq));
	led_matrix_host #(.DETECT_WAIT(6000)) i_led_matrix_host (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.irq(irq), .link(link.host));
	led_link_assertions i_led_link_assertions (.aclk(aclk), .aresetn(aresetn), .req(link.req),
		.we(link.we), .page(link.page), .addr(link.addr), .wdata(link.wdata),
		.rdata(link.rdata), .ack(link.ack), .shutdown_pin_n(link.shutdown_pin_n),
		.dev_irq(link.dev_irq));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// sampled at the falling edge so the rising edge decides without a race
	task automatic await(input int b);
		logic hs;
		do begin
			@(negedge aclk);
			hs = hsv[b];
			@(posedge aclk);
		end while (!hs);
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'b00);
		bexp.push_back(e);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		await(0);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		await(1);
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = '1,
			input logic [1:0] e = 2'b00);
		rexp.push_back(x);
		rmask.push_back(m);
		rrexp.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		await(2);
		arvalid <= 1'b0;
		await(3);
	endtask

	// one link access; waits on the done interrupt, then clears it
	task automatic lk(input logic [1:0] p, input logic [7:0] a, input logic [7:0] d,
			input logic w = 1'b1, input bit dn = 1'b1);
		axi_wr(`HREG_ADDR, {22'h0, p, a});
		axi_wr(`HREG_WDATA, {24'h0, d});
		axi_wr(`HREG_CTRL, {29'h0, pin, w, 1'b1});
		if (dn) begin
			repeat (40000) begin
				@(negedge aclk);
				if (irq)
					break;
			end
			check({31'h0, irq}, 32'h1);
			@(posedge aclk);
			axi_wr(`HREG_IST, 32'h1);
		end
	endtask

	task automatic lrd(input logic [1:0] p, input logic [7:0] a, input logic [7:0] x);
		lk(p, a, 8'h00, 1'b0);
		axi_rd(`HREG_RDATA, {24'h0, x});
	endtask

	// matrix outputs stay dark for a full scan and more
	task automatic quiet(input logic ae);
		cnt = 0;
		repeat (3000) begin
			@(negedge aclk);
			cnt |= {2'h0, aen, src_on, sink_on};
		end
		@(posedge aclk);
		check(cnt, {2'h0, ae, 29'h0});
	endtask

	// compare each response with the oldest note
	always @(negedge aclk) begin
		if (awvalid && wvalid)
			check({31'h0, wready}, {31'h0, !bvalid});
		if (bvalid && bready)
			check({30'h0, bresp}, {30'h0, bexp.pop_front()});
		if (rvalid && rready) begin
			check({30'h0, rresp}, {30'h0, rrexp.pop_front()});
			check(rdata & rmask.pop_front(), rexp.pop_front());
		end
	end

	// a pull never loads a conducting line
	always @(negedge aclk) begin
		if (aresetn)
			check({3'h0, src_on & src_pe, sink_on & sink_pe}, 32'h0);
	end

	// hang guard, about twice the expected run length
	initial begin
		#400000;
		mismatches++;
		end_of_test();
	end

	initial begin
		void'($urandom(25301));
		dv[2] = 8'($urandom);
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_rd(`HREG_CTRL, 32'h4);
		axi_rd(8'h1c, 32'h0, '1, 2'b10);
		axi_wr(8'h1c, 32'h5, 2'b10);
		axi_wr(`HREG_IMASK, 32'h1);
		foreach (fa[i]) lrd(2'd2, fa[i], 8'h00);
		lk(2'd2, `REG_PULL, 8'h32);
		check({26'h0, spc, kpc}, {26'h0, 3'd3, 3'd2});
		lk(2'd1, 8'h00, 8'h01);
		lk(2'd2, `REG_CFG, 8'h01);
		check({31'h0, sink_pe[1]}, 32'h1);
		foreach (dv[i]) begin
			lk(2'd0, 8'h00, dv[i]);
			@(posedge src_on[0]);
			cnt = 0;
			repeat (256) begin
				@(negedge aclk);
				cnt += sink_on[0];
			end
			@(posedge aclk);
			check(cnt, {24'h0, dv[i]});
		end
		lk(2'd2, `REG_CFG, 8'h00);
		quiet(1'b1);
		lrd(2'd0, 8'h00, 8'hff);
		lk(2'd2, `REG_CFG, 8'h01);
		pin = 1'b0;
		axi_wr(`HREG_CTRL, 32'h0);
		quiet(1'b0);
		g = 8'($urandom_range(32'h40, 32'h0f));
		lk(2'd2, `REG_GCC, g);
		lrd(2'd2, `REG_GCC, g);
		pin = 1'b1;
		axi_wr(`HREG_CTRL, 32'h4);
		check({31'h0, aen}, 32'h1);
		lrd(2'd0, 8'h00, 8'hff);
		axi_wr(`HREG_IMASK, 32'h0);
		lk(2'd0, 8'h01, 8'h10, 1'b1, 1'b0);
		repeat (20) @(posedge aclk);
		check({31'h0, irq}, 32'h0);
		axi_wr(`HREG_IMASK, 32'h1);
		check({31'h0, irq}, 32'h1);
		axi_wr(`HREG_IST, 32'h1);
		check({31'h0, irq}, 32'h0);
		lk(2'd2, `REG_GCC, 8'h05);
		lk(2'd2, `REG_PULL, 8'h00);
		lk(2'd2, `REG_CFG, 8'h03, 1'b1, 1'b0);
		repeat (4) @(posedge aclk);
		axi_rd(`HREG_IST, 32'h2, 32'h2);
		axi_wr(`HREG_IST, 32'h7);
		lk(2'd2, `REG_IMASK, 8'h01);
		lk(2'd2, `REG_GCC, g);
		osense <= 18'($urandom);
		lk(2'd2, `REG_CFG, 8'h03);
		axi_rd(`HREG_STAT, 32'h2, 32'h2);
		lrd(2'd2, `REG_RES_FIRST, {7'h0, osense[0]});
		axi_rd(`HREG_IST, 32'h4, 32'h4);
		check({31'h0, dirq}, 32'h1);
		lrd(2'd2, `REG_IST, {6'h0, osense[0], 1'b1});
		lk(2'd2, `REG_IST, 8'hff);
		check({31'h0, dirq}, 32'h0);
		lk(2'd2, `REG_GCC, 8'h01);
		lk(2'd2, `REG_PULL, 8'h30);
		check({21'h0, src_pe | src_on}, {21'h0, 11'h7ff});
		ssense <= 18'($urandom);
		lk(2'd2, `REG_CFG, 8'h05);
		keep = {7'h0, ssense[0]};
		lrd(2'd2, `REG_RES_FIRST, keep);
		lk(2'd1, 8'h00, 8'h00);
		ssense <= ~ssense;
		lk(2'd2, `REG_CFG, 8'h05);
		lrd(2'd2, `REG_RES_FIRST, keep);
		lk(2'd2, `REG_RESET, `RESET_KEY);
		lrd(2'd2, `REG_GCC, 8'h00);
		lrd(2'd0, 8'h00, 8'h00);
		end_of_test();
	end
endmodule
